/* hw/icts_pkg.sv */
package icts_pkg;

  // ==========================================================
  // Bus timing and clock
  // ==========================================================
  localparam int ICTS_MCLK_HZ = 40_000_000;
  localparam int ICTS_BUS_BPS = 400_000;
  // Core cycles in one bus bit period, at fastest bus rate
  localparam int ICTS_BIT_CYC = ICTS_MCLK_HZ / ICTS_BUS_BPS;

  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [7:0] ICTS_CMD_WRITE = 8'h02;
  localparam logic [7:0] ICTS_CMD_READ = 8'h03;
  localparam logic [7:0] ICTS_CMD_RDSR = 8'h05;
  localparam logic [7:0] ICTS_CMD_WREN = 8'h06;

  // ==========================================================
  // Byte framing
  // ==========================================================
  localparam logic [3:0] ICTS_LAST_BIT = 4'h7;
  localparam logic [3:0] ICTS_ACK_BIT = 4'h8;
  localparam logic [3:0] ICTS_FIRST_CNT = 4'h1;
  localparam logic [1:0] ICTS_IDX_CMD = 2'h0;
  localparam logic [1:0] ICTS_IDX_AHI = 2'h1;
  localparam logic [1:0] ICTS_IDX_ALO = 2'h2;
  localparam logic [1:0] ICTS_IDX_DATA = 2'h3;

  // ==========================================================
  // Address map and reset values
  // ==========================================================
  localparam logic [15:0] ICTS_BANK_ADDR = 16'h0000;
  localparam logic [15:0] ICTS_ADDR_INC = 16'h0001;
  localparam logic [1:0] ICTS_STRAP_TAKE = 2'h3;
  localparam logic [6:0] ICTS_PAD7 = 7'h00;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_ADDR = 4'b0010,
    L_WRITE = 4'b0100,
    L_READ = 4'b1000
  } icts_lnk_t;

  typedef enum logic [4:0] {
    EV_HIT_W = 5'b00001,
    EV_HIT_R = 5'b00010,
    EV_MISS = 5'b00100,
    EV_DATA = 5'b01000,
    EV_RD_ACK = 5'b10000
  } icts_ev_t;

  typedef enum logic [3:0] {
    SRC_BANK = 4'b0001,
    SRC_REG = 4'b0010,
    SRC_MEM = 4'b0100,
    SRC_STAT = 4'b1000
  } icts_src_t;

endpackage : icts_pkg

/* hw/icts_cond_if.sv */
`timescale 1ns/1ps
interface icts_cond_if;
  logic start_tgl;
  logic stop_tgl;
  // Detector side drives the condition toggles
  modport det (output start_tgl, output stop_tgl);
  // Link and core sides read them
  modport usr (input start_tgl, input stop_tgl);
endinterface : icts_cond_if

/* hw/icts_sync.sv */
`timescale 1ns/1ps
module icts_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ==========================================================
  // Two-stage synchroniser per bit
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_r;
      // First stage is read by the second stage only
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_r <= 1'b0;
          q_o[gi] <= 1'b0;
        end else begin
          meta_r <= d_i[gi];
          q_o[gi] <= meta_r;
        end
      end
    end
  endgenerate
endmodule : icts_sync

/* hw/icts_cond.sv */
`timescale 1ns/1ps
module icts_cond (
  // Reset
  input wire logic rst_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  // Condition toggles
  icts_cond_if.det cond
);
  // ==========================================================
  // Start and stop detection
  // ==========================================================
  // Data line falling while clock high marks a start
  always_ff @(negedge sda_i or posedge rst_i) begin
    if (rst_i) begin
      cond.start_tgl <= 1'b0;
    end else if (scl_i) begin
      cond.start_tgl <= ~cond.start_tgl;
    end
  end

  // Data line rising while clock high marks a stop
  always_ff @(posedge sda_i or posedge rst_i) begin
    if (rst_i) begin
      cond.stop_tgl <= 1'b0;
    end else if (scl_i) begin
      cond.stop_tgl <= ~cond.stop_tgl;
    end
  end
endmodule : icts_cond

/* hw/icts_top.sv */
`timescale 1ns/1ps
module icts_top #(
  // Slave address choices, values arbitrary
  parameter logic [6:0] SADDR0 = 7'h21,
  parameter logic [6:0] SADDR1 = 7'h22,
  parameter logic [6:0] SADDR2 = 7'h23,
  parameter bit HAS_MEM = 1'b1
) (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  // Bus pins
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic scl_o,
  output logic scl_oe_n_o,
  // Straps, soft reset and device status
  input wire logic [1:0] addr_sel_i,
  input wire logic soft_rst_i,
  input wire logic mem_busy_i,
  // Internal access port
  input wire logic [7:0] reg_rdata_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] bus_addr_o,
  output logic [7:0] bus_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic mem_wr_o,
  output logic mem_rd_o,
  output logic mem_commit_o,
  output logic memory_bank_select_o
);
  // ==========================================================
  // Shared declarations
  // ==========================================================
  icts_cond_if cond ();
  icts_pkg::icts_lnk_t lnk_st_r;
  icts_pkg::icts_ev_t ev_kind_r;
  icts_pkg::icts_src_t src_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, ev_byte_r, tx_hold_r, tx_byte_r, cmd_r;
  logic [6:0] slave_addr_r;
  logic start_seen_r, ev_tgl_r, ack_en_r, rd_req_r;
  logic [3:0] sync_q;
  logic ev_seen_r, stop_seen_r, fetch_pend_r, frame_open_r;
  logic [1:0] strap_cnt_r, byte_idx_r;
  logic [15:0] wr_ptr_r, rd_base_r, rd_ptr_r;
  logic rd_fresh_r, rd_rpt_r, status_mode_r, wel_r, bank_sel_r, mem_dirty_r;
  logic [7:0] rx_byte;
  logic start_new, addr_hit;

  // Hardware reset only
  // Pin reset arrives active high here; soft reset never reaches the link
  icts_cond u_cond (.rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .cond(cond));

  // ==========================================================
  // Link side, clocked by the bus clock
  // ==========================================================
  // Shift in MSB first
  assign rx_byte = {shift_r[6:0], sda_i};
  // Plain seven-bit match
  // Straps never select address zero, so general call is ignored
  assign addr_hit = (rx_byte[7:1] == slave_addr_r);
  // Toggle set a full hold time before this rising edge
  assign start_new = (cond.start_tgl != start_seen_r);

  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      start_seen_r <= 1'b0;
    end else begin
      start_seen_r <= cond.start_tgl;
    end
  end

  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      lnk_st_r <= icts_pkg::L_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_new) begin
      lnk_st_r <= icts_pkg::L_ADDR;
      bit_cnt_r <= icts_pkg::ICTS_FIRST_CNT;
      shift_r <= {icts_pkg::ICTS_PAD7, sda_i};
    end else begin
      case (lnk_st_r)
        icts_pkg::L_ADDR, icts_pkg::L_WRITE: begin
          if (bit_cnt_r == icts_pkg::ICTS_ACK_BIT) begin
            bit_cnt_r <= 4'h0;
            if (lnk_st_r == icts_pkg::L_ADDR) begin
              lnk_st_r <= rd_req_r ? icts_pkg::L_READ : icts_pkg::L_WRITE;
            end
          end else begin
            shift_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (lnk_st_r == icts_pkg::L_ADDR && bit_cnt_r == icts_pkg::ICTS_LAST_BIT
                && !addr_hit) begin
              lnk_st_r <= icts_pkg::L_IDLE;
            end
          end
        end
        icts_pkg::L_READ: begin
          if (bit_cnt_r == icts_pkg::ICTS_ACK_BIT) begin
            bit_cnt_r <= 4'h0;
            if (sda_i) begin
              lnk_st_r <= icts_pkg::L_IDLE;
            end
          end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        default: begin
          bit_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      ack_en_r <= 1'b0;
      rd_req_r <= 1'b0;
    end else if (!start_new && bit_cnt_r == icts_pkg::ICTS_LAST_BIT) begin
      ack_en_r <= (lnk_st_r == icts_pkg::L_WRITE) ||
                  (lnk_st_r == icts_pkg::L_ADDR && addr_hit);
      rd_req_r <= rx_byte[0];
    end
  end

  // Event toggle toward the core; kind and byte hold for a whole byte time
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      ev_tgl_r <= 1'b0;
      ev_kind_r <= icts_pkg::EV_MISS;
      ev_byte_r <= 8'h00;
    end else if (!start_new && bit_cnt_r == icts_pkg::ICTS_LAST_BIT &&
                 (lnk_st_r == icts_pkg::L_ADDR || lnk_st_r == icts_pkg::L_WRITE)) begin
      ev_tgl_r <= ~ev_tgl_r;
      ev_byte_r <= rx_byte;
      if (lnk_st_r == icts_pkg::L_WRITE) begin
        ev_kind_r <= icts_pkg::EV_DATA;
      end else if (!addr_hit) begin
        ev_kind_r <= icts_pkg::EV_MISS;
      end else begin
        ev_kind_r <= rx_byte[0] ? icts_pkg::EV_HIT_R : icts_pkg::EV_HIT_W;
      end
    end else if (!start_new && lnk_st_r == icts_pkg::L_READ &&
                 bit_cnt_r == icts_pkg::ICTS_ACK_BIT && !sda_i) begin
      ev_tgl_r <= ~ev_tgl_r;
      ev_kind_r <= icts_pkg::EV_RD_ACK;
    end
  end

  // Data line driven on falling clock; tx_byte_r settled long before
  always_ff @(negedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
      tx_hold_r <= 8'h00;
    end else begin
      sda_o <= 1'b0;
      if (lnk_st_r == icts_pkg::L_READ && bit_cnt_r == 4'h0) begin
        tx_hold_r <= tx_byte_r;
        sda_oe_n_o <= tx_byte_r[7];
      end else if (lnk_st_r == icts_pkg::L_READ && bit_cnt_r < icts_pkg::ICTS_ACK_BIT) begin
        sda_oe_n_o <= tx_hold_r[3'(icts_pkg::ICTS_LAST_BIT - bit_cnt_r)];
      end else if (bit_cnt_r == icts_pkg::ICTS_ACK_BIT && ack_en_r &&
                   lnk_st_r != icts_pkg::L_READ && lnk_st_r != icts_pkg::L_IDLE) begin
        sda_oe_n_o <= 1'b0;
      end else begin
        sda_oe_n_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Core side, clocked by the master clock
  // ==========================================================
  icts_sync #(.W(4)) u_sync (
    .mclk_i(mclk_i), .rst_i(rst_i),
    .d_i({addr_sel_i, cond.stop_tgl, ev_tgl_r}), .q_o(sync_q));

  logic ev_new, stop_new, addr_ev, fin, fetch_go, wr_go;
  logic fresh_set, rdsr_set, wren_set, commit_set, rpt_now, stat_now;
  logic [15:0] fetch_addr;
  assign ev_new = (sync_q[0] != ev_seen_r);
  assign stop_new = (sync_q[1] != stop_seen_r);
  assign addr_ev = ev_new && (ev_kind_r != icts_pkg::EV_DATA) &&
                   (ev_kind_r != icts_pkg::EV_RD_ACK);
  // Stop or new address closes frame
  assign fin = frame_open_r && (stop_new || addr_ev);
  assign fresh_set = fin && cmd_r == icts_pkg::ICTS_CMD_READ &&
                     byte_idx_r == icts_pkg::ICTS_IDX_DATA;
  assign rdsr_set = fin && cmd_r == icts_pkg::ICTS_CMD_RDSR &&
                    byte_idx_r == icts_pkg::ICTS_IDX_AHI;
  assign wren_set = fin && cmd_r == icts_pkg::ICTS_CMD_WREN &&
                    byte_idx_r == icts_pkg::ICTS_IDX_AHI;
  assign commit_set = fin && cmd_r == icts_pkg::ICTS_CMD_WRITE && mem_dirty_r;
  assign wr_go = ev_new && ev_kind_r == icts_pkg::EV_DATA && frame_open_r &&
                 byte_idx_r == icts_pkg::ICTS_IDX_DATA && cmd_r == icts_pkg::ICTS_CMD_WRITE;
  assign fetch_go = ev_new && (ev_kind_r == icts_pkg::EV_HIT_R ||
                    ev_kind_r == icts_pkg::EV_RD_ACK);
  assign rpt_now = (ev_kind_r == icts_pkg::EV_HIT_R) ? !(rd_fresh_r || fresh_set) : rd_rpt_r;
  assign stat_now = rdsr_set || (status_mode_r && !fresh_set);
  assign fetch_addr = fresh_set ? wr_ptr_r : (rpt_now ? rd_base_r : rd_ptr_r);

  // Event and stop edge tracking
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else begin
      ev_seen_r <= sync_q[0];
      stop_seen_r <= sync_q[1];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_r <= 2'h0;
      slave_addr_r <= SADDR0;
    end else if (strap_cnt_r != icts_pkg::ICTS_STRAP_TAKE) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      case (sync_q[3:2])
        2'h1: slave_addr_r <= SADDR1;
        2'h2: slave_addr_r <= SADDR2;
        default: slave_addr_r <= SADDR0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_open_r <= 1'b0;
      byte_idx_r <= icts_pkg::ICTS_IDX_CMD;
      cmd_r <= 8'h00;
      wr_ptr_r <= 16'h0000;
    end else if (ev_new && ev_kind_r == icts_pkg::EV_HIT_W) begin
      frame_open_r <= 1'b1;
      byte_idx_r <= icts_pkg::ICTS_IDX_CMD;
      cmd_r <= 8'h00;
    end else if (fin) begin
      frame_open_r <= 1'b0;
    end else if (ev_new && ev_kind_r == icts_pkg::EV_DATA && frame_open_r) begin
      case (byte_idx_r)
        icts_pkg::ICTS_IDX_CMD: cmd_r <= ev_byte_r;
        icts_pkg::ICTS_IDX_AHI: wr_ptr_r[15:8] <= ev_byte_r;
        icts_pkg::ICTS_IDX_ALO: wr_ptr_r[7:0] <= ev_byte_r;
        default: wr_ptr_r <= wr_ptr_r + icts_pkg::ICTS_ADDR_INC;
      endcase
      if (byte_idx_r != icts_pkg::ICTS_IDX_DATA) begin
        byte_idx_r <= byte_idx_r + 2'h1;
      end
    end
  end

  // Read pointer, freshness and status mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_base_r <= 16'h0000;
      rd_ptr_r <= 16'h0000;
      rd_fresh_r <= 1'b0;
      rd_rpt_r <= 1'b0;
      status_mode_r <= 1'b0;
    end else begin
      status_mode_r <= stat_now;
      if (fresh_set) begin
        rd_base_r <= wr_ptr_r;
        rd_ptr_r <= wr_ptr_r;
      end
      if (fetch_go && !rpt_now && !stat_now) begin
        rd_ptr_r <= fetch_addr + icts_pkg::ICTS_ADDR_INC;
      end
      if (ev_new && ev_kind_r == icts_pkg::EV_HIT_R) begin
        rd_rpt_r <= rpt_now;
      end
      // Any other transaction makes the setup stale
      if (addr_ev) begin
        rd_fresh_r <= 1'b0;
      end else if (fresh_set || rdsr_set) begin
        rd_fresh_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_r <= 1'b0;
      bank_sel_r <= 1'b0;
      mem_dirty_r <= 1'b0;
    end else begin
      if (wr_go && wr_ptr_r == icts_pkg::ICTS_BANK_ADDR) begin
        bank_sel_r <= ev_byte_r[0];
      end else if (soft_rst_i) begin
        bank_sel_r <= 1'b0;
      end
      // Enable set wins over soft reset and commit clear
      if (wren_set) begin
        wel_r <= 1'b1;
      end else if (soft_rst_i || commit_set) begin
        wel_r <= 1'b0;
      end
      if (ev_new && ev_kind_r == icts_pkg::EV_HIT_W) begin
        mem_dirty_r <= 1'b0;
      end else if (mem_wr_o) begin
        mem_dirty_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_addr_o <= 16'h0000;
      bus_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_commit_o <= 1'b0;
      fetch_pend_r <= 1'b0;
      src_r <= icts_pkg::SRC_STAT;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_commit_o <= commit_set;
      fetch_pend_r <= fetch_go;
      if (wr_go) begin
        bus_addr_o <= wr_ptr_r;
        bus_wdata_o <= ev_byte_r;
        if (wr_ptr_r != icts_pkg::ICTS_BANK_ADDR) begin
          reg_wr_o <= !bank_sel_r;
          mem_wr_o <= bank_sel_r && wel_r && HAS_MEM;
        end
      end else if (fetch_go) begin
        bus_addr_o <= fetch_addr;
        if (stat_now) begin
          src_r <= icts_pkg::SRC_STAT;
        end else if (fetch_addr == icts_pkg::ICTS_BANK_ADDR) begin
          src_r <= icts_pkg::SRC_BANK;
        end else if (bank_sel_r && HAS_MEM) begin
          src_r <= icts_pkg::SRC_MEM;
          mem_rd_o <= 1'b1;
        end else begin
          src_r <= icts_pkg::SRC_REG;
          reg_rd_o <= !bank_sel_r;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_byte_r <= 8'h00;
    end else if (fetch_pend_r) begin
      case (src_r)
        icts_pkg::SRC_BANK: tx_byte_r <= {icts_pkg::ICTS_PAD7, bank_sel_r};
        icts_pkg::SRC_REG: tx_byte_r <= reg_rdata_i;
        icts_pkg::SRC_MEM: tx_byte_r <= mem_rdata_i;
        default: tx_byte_r <= {icts_pkg::ICTS_PAD7, mem_busy_i};
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      memory_bank_select_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      memory_bank_select_o <= bank_sel_r;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_scl_never_held: assert property (
    @(posedge mclk_i) disable iff (rst_i) scl_oe_n_o)
    else $error("clock line driven");
  chk_ack_own_addr: assert property (
    @(posedge scl_i) disable iff (rst_i)
    (bit_cnt_r == icts_pkg::ICTS_ACK_BIT && ack_en_r && lnk_st_r == icts_pkg::L_ADDR)
    |-> !sda_oe_n_o)
    else $error("address not acked");
  chk_idle_released: assert property (
    @(posedge scl_i) disable iff (rst_i) (lnk_st_r == icts_pkg::L_IDLE) |-> sda_oe_n_o)
    else $error("data driven while idle");
  chk_tx_msb_first: assert property (
    @(posedge scl_i) disable iff (rst_i)
    (lnk_st_r == icts_pkg::L_READ && bit_cnt_r < icts_pkg::ICTS_ACK_BIT)
    |-> sda_oe_n_o == tx_hold_r[3'(icts_pkg::ICTS_LAST_BIT - bit_cnt_r)])
    else $error("wrong read bit");
  chk_write_incr: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (reg_wr_o || mem_wr_o) |-> wr_ptr_r == bus_addr_o + icts_pkg::ICTS_ADDR_INC)
    else $error("pointer not advanced");
  chk_bank_route: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (reg_wr_o |-> !bank_sel_r) and (mem_wr_o |-> bank_sel_r && wel_r))
    else $error("write to wrong bank");
  chk_addr0_local: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (reg_wr_o || reg_rd_o || mem_wr_o || mem_rd_o) |-> bus_addr_o != icts_pkg::ICTS_BANK_ADDR)
    else $error("address zero left block");
  chk_short_frame: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (fin && byte_idx_r != icts_pkg::ICTS_IDX_DATA) |=> !mem_commit_o && $stable(rd_base_r))
    else $error("short frame acted");
  chk_status_lsb: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (fetch_pend_r && src_r == icts_pkg::SRC_STAT)
    |=> tx_byte_r == {icts_pkg::ICTS_PAD7, $past(mem_busy_i)})
    else $error("status byte wrong");
  chk_repeat_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (fetch_go && rpt_now && !fresh_set) |=> $stable(rd_ptr_r) ##1 $stable(rd_ptr_r))
    else $error("stale read moved pointer");
  chk_fetch_time: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    fetch_go |=> bus_addr_o == $past(fetch_addr) && (reg_rd_o || mem_rd_o ||
    src_r == icts_pkg::SRC_BANK || src_r == icts_pkg::SRC_STAT))
    else $error("fetch not issued");
  chk_soft_bank: assert property (
    @(posedge mclk_i) disable iff (rst_i) (soft_rst_i && !wr_go) |=> !bank_sel_r)
    else $error("soft reset kept bank");
  cov_reg_write: cover property (@(posedge mclk_i) disable iff (rst_i) reg_wr_o);
  cov_mem_commit: cover property (@(posedge mclk_i) disable iff (rst_i) mem_commit_o);
  cov_status_read: cover property (
    @(posedge mclk_i) disable iff (rst_i) fetch_pend_r && src_r == icts_pkg::SRC_STAT);
  cov_stale_read: cover property (@(posedge mclk_i) disable iff (rst_i) fetch_go && rpt_now);
endmodule : icts_top

/* test/icts_mst.sv */
`timescale 1ns/1ps
// ==========
// Bus master model
module icts_mst (
  // Core clock
  input wire logic mclk_i,
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // master owns the clock, idle high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One bus step; three steps and a sample keep the bit under 400k
  task automatic q(input logic c, input logic d);
    repeat (30) @(posedge mclk_i);
    scl_o <= c;
    sda_o <= d;
  endtask : q
  task automatic start();
    q(1'b0, sda_o);
    q(1'b0, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    q(1'b0, sda_o);
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
  endtask : stop
  // msb first, nack in bit 0
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      q(1'b0, sda_o);
      q(1'b0, d[i]);
      q(1'b1, d[i]);
      repeat (12) @(posedge mclk_i);
      r[i] = sda_i;
    end
  endtask : xfer
endmodule : icts_mst

/* test/tb_top.sv */
`timescale 1ns/1ps
// ==========
// Bench top
module tb_top;
  localparam logic [7:0] Z = 8'h00;
  logic mclk_i, rst_i, mem_busy_i, scl_w, sda_w, m_scl, m_sda, sda_o, sda_oe_n_o;
  logic scl_o, scl_oe_n_o, reg_wr_o, reg_rd_o, mem_wr_o, mem_rd_o, mem_commit_o, bank;
  logic [15:0] bus_addr_o;
  logic [7:0] bus_wdata_o, d0, d1, d2;
  logic [6:0] sa;
  logic [1:0] addr_sel_i;
  logic soft_rst_i;
  logic [7:0] regs [256];
  logic [7:0] mem [256];
  int num_errors = 0, comparisons = 0, nwr = 0, ncm = 0, nstr = 0;
  // Open-drain wires with pull-up
  assign sda_w = m_sda & (sda_oe_n_o | sda_o);
  assign scl_w = m_scl & (scl_oe_n_o | scl_o);
  icts_mst icts_mst_i (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  icts_top icts_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .addr_sel_i(addr_sel_i), .soft_rst_i(soft_rst_i), .mem_busy_i(mem_busy_i),
    .reg_rdata_i(regs[bus_addr_o[7:0]]), .mem_rdata_i(mem[bus_addr_o[7:0]]),
    .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
    .mem_commit_o(mem_commit_o), .memory_bank_select_o(bank));
  // Register and memory model; reads answer at once
  always @(posedge mclk_i) begin
    if (reg_wr_o === 1'b1) begin
      regs[bus_addr_o[7:0]] <= bus_wdata_o;
      nwr <= nwr + 1;
    end
    if (mem_wr_o === 1'b1) mem[bus_addr_o[7:0]] <= bus_wdata_o;
    if (mem_commit_o === 1'b1) ncm <= ncm + 1;
    if (scl_w !== m_scl) nstr <= nstr + 1;
  end
  // Core clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Watchdog, well above the roughly 74k cycle sequence
  initial begin
    repeat (90000) @(posedge mclk_i);
    num_errors++;
    conclude();
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Byte out, ack level checked
  task automatic wb(input logic [7:0] b, input logic e);
    logic [8:0] r;
    icts_mst_i.xfer({b, 1'b1}, r);
    chk({7'h0, r[0]}, {7'h0, e});
  endtask : wb
  // Write frame of n bytes
  task automatic wf(input int n, input logic [7:0] b0, b1, b2, b3, b4);
    logic [7:0] b [5];
    b = '{b0, b1, b2, b3, b4};
    icts_mst_i.start();
    wb({sa, 1'b0}, 1'b0);
    for (int i = 0; i < n; i++) wb(b[i], 1'b0);
    icts_mst_i.stop();
  endtask : wf
  // Read frame, ack then nack
  task automatic rd(input logic [7:0] e0, input logic [7:0] e1);
    logic [8:0] r;
    icts_mst_i.start();
    wb({sa, 1'b1}, 1'b0);
    icts_mst_i.xfer(9'h1FE, r);
    chk(r[8:1], e0);
    icts_mst_i.xfer(9'h1FF, r);
    chk(r[8:1], e1);
    icts_mst_i.stop();
  endtask : rd
  // Expected status byte: busy flag in bit 0
  function automatic logic [7:0] stat_byte(input logic busy);
    return {7'h00, busy};
  endfunction : stat_byte
  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    rst_i = 1'b1;
    soft_rst_i = 1'b0;
    addr_sel_i = 2'h0;
    sa = 7'h21;
    mem_busy_i = 1'b0;
    foreach (mem[i]) mem[i] = Z;
    d0 = 8'($urandom(1204));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4000) @(posedge mclk_i);
    wf(5, 8'h02, Z, 8'h10, d0, d1);
    chk(regs[8'h10], d0);
    chk(regs[8'h11], d1);
    wf(3, 8'h03, Z, 8'h10, Z, Z);
    rd(d0, d1);
    wf(3, 8'h03, Z, 8'h10, Z, Z);
    icts_mst_i.start();
    wb(8'hA0, 1'b1);
    rd(d0, d0);
    wf(2, 8'h02, Z, Z, Z, Z);
    chk(8'(nwr), 8'h02);
    wf(4, 8'h02, Z, Z, 8'h01, Z);
    chk({7'h0, bank}, 8'h01);
    wf(4, 8'h02, Z, 8'h31, d2, Z);
    wf(1, 8'h06, Z, Z, Z, Z);
    wf(4, 8'h02, Z, 8'h30, d2, Z);
    chk(mem[8'h31], Z);
    chk(mem[8'h30], d2);
    wf(3, 8'h03, Z, Z, Z, Z);
    rd(8'h01, Z);
    mem_busy_i <= 1'b1;
    wf(1, 8'h05, Z, Z, Z, Z);
    rd(stat_byte(1'b1), stat_byte(1'b1));
    mem_busy_i <= 1'b0;
    rd(stat_byte(1'b0), stat_byte(1'b0));
    // Soft reset drops bank select and the write enable
    soft_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    soft_rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk({7'h0, bank}, Z);
    // Pin reset cuts a write frame; the new strap takes effect
    icts_mst_i.start();
    wb({sa, 1'b0}, 1'b0);
    wb(8'h02, 1'b0);
    addr_sel_i <= 2'h1;
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    icts_mst_i.stop();
    repeat (4000) @(posedge mclk_i);
    sa = 7'h22;
    icts_mst_i.start();
    wb(8'h42, 1'b1);
    wf(3, 8'h03, Z, 8'h10, Z, Z);
    rd(d0, d1);
    chk(8'(nwr), 8'h02);
    chk(8'(ncm), 8'h01);
    chk(8'(nstr), Z);
    conclude();
  end
endmodule : tb_top
